//--- common/sera_pkg.sv
// constants, enums and carriers of the serial rom register autoloader
// assumes a 40 MHz block clock and a 256 x 8 two-wire rom on the link
package sera_pkg;
    // ========================================================
    // timing
    localparam int CLK_PERIOD_NS = 25;
    localparam int ROM_QTR_NS    = 2500;
    localparam int ROM_QTR_CYC   = (ROM_QTR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int ROM_WRITE_NS  = 5000000;
    localparam int ROM_WRITE_CYC = ROM_WRITE_NS / CLK_PERIOD_NS;
    localparam logic [1:0] BOOT_WAIT = 2'h3;

    // ========================================================
    // register map
    localparam logic [7:0] REG_CTRL     = 8'h00;
    localparam logic [7:0] REG_DATA     = 8'h04;
    localparam logic [7:0] REG_STATUS   = 8'h08;
    localparam logic [7:0] REG_IRQ_STAT = 8'h0C;
    localparam logic [7:0] REG_IRQ_MASK = 8'h10;
    localparam logic [7:0] REG_BRIDGE   = 8'h14;
    localparam int IMG_SEL_BIT    = 7;
    localparam int CTRL_START_BIT = 0;
    localparam int CTRL_WRITE_BIT = 1;
    localparam int CTRL_ADDR_LSB  = 8;
    localparam int ST_LOAD_BUSY   = 0;
    localparam int ST_CYCLE       = 1;
    localparam int ST_SIG_OK      = 2;
    localparam int ST_ENABLED     = 3;
    localparam int ST_PROTECT     = 4;
    localparam int IRQ_W          = 3;
    localparam int IRQ_LOAD_DONE  = 0;
    localparam int IRQ_SW_DONE    = 1;
    localparam int IRQ_ACK_ERR    = 2;
    localparam int BRIDGE_WP_BIT  = 2;
    localparam logic [15:0] BRIDGE_RST = 16'h0000;
    localparam logic [15:0] IMG_RST    = 16'h0000;

    // ========================================================
    // rom image layout
    localparam logic [3:0] ROM_SEL_TYPE = 4'hA;
    localparam logic [2:0] ROM_DEV_ADDR = 3'h0;
    localparam logic [6:0] SIG_WORD     = 7'h00;
    localparam logic [6:0] REGION_WORD  = 7'h01;
    localparam int REGION_LSB  = 1;
    localparam int PROTECT_BIT = 8;
    localparam logic [3:0] REGION_G2 = 4'h1;
    localparam logic [3:0] REGION_G3 = 4'h3;
    localparam logic [3:0] REGION_G4 = 4'h7;
    localparam logic [3:0] REGION_G5 = 4'hF;
    localparam logic [6:0] LAST_G1 = 7'h01;
    localparam logic [6:0] LAST_G2 = 7'h09;
    localparam logic [6:0] LAST_G3 = 7'h11;
    localparam logic [6:0] LAST_G4 = 7'h13;

    // ========================================================
    // types
    typedef enum logic [2:0] {
        MS_BOOT   = 3'b000,
        MS_XFER   = 3'b001,
        MS_WAITWR = 3'b010,
        MS_IDLE   = 3'b011
    } sera_main_e;

    typedef enum logic [2:0] {
        ENG_IDLE  = 3'b000,
        ENG_START = 3'b001,
        ENG_STOP  = 3'b010,
        ENG_TX    = 3'b011,
        ENG_RX    = 3'b100
    } sera_eng_e;

    typedef struct packed {
        logic [7:0]  addr;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
    } sera_bus_s;

    typedef struct packed {
        sera_eng_e  kind;
        logic [7:0] data;
        logic       lsbFirst;
        logic       ackLow;
        logic       last;
    } sera_item_s;
endpackage : sera_pkg

//--- src/sera_autoloader.sv
// serial rom interface and register autoloader of the bridge
// assumes rst_b is the primary reset, a plain register port on clk,
// and a two-wire rom whose address straps are tied to zero
//
// How it works
// R01 - load starts by itself after reset release
// R02 - seven-bit word address, little-endian byte pairs
// R03 - drive serial clock, turn data line around
// R04 - rom accesses only while enable low
// R05 - select phase always sends device address zero
// R06 - software start runs one word access
// R07 - software waits for cycle status clear
// R08 - load proceeds only on signature match
// R09 - sequential words into their mapped registers
// R10 - busy status high while loading, then zero
// R11 - data bits reversed against address bits
// R12 - region code sets last loaded word
// R13 - loaded protect bit freezes bridge bit two
// R14 - group two: identity, class, header words
// R15 - group three: prefetch counts bytes 18h-1Dh
// R16 - group three: options and power management
// R17 - reserved image bytes are zero
// R18 - skip load keeps reset values, busy clears
// R19 - start, select, acks and stop frame transfers
//
// Decided for this implementation: the register addresses and the address-and-strobe port.
`timescale 1ns/1ps
module sera_autoloader #(
    parameter int          QTR_CYC        = sera_pkg::ROM_QTR_CYC,
    parameter int          WRITE_WAIT_CYC = sera_pkg::ROM_WRITE_CYC,
    parameter int          IMG_WORDS      = 32,
    parameter logic [6:0]  LOAD_ALL_LAST  = 7'h1F,
    // arbitrary value
    parameter logic [15:0] SIGNATURE      = 16'hC35A
) (
    input  wire logic                clk,
    input  wire logic                rst_b,
    input  wire sera_pkg::sera_bus_s regBus,
    output logic [31:0]              rdData,
    output logic                     irq,
    output logic                     autoloadBusyStatus,
    output logic                     romSerialClockOut,
    input  wire logic                romSerialDataIoIn,
    output logic                     romSerialDataIoOut,
    output logic                     romSerialDataIoOe,
    input  wire logic                romLoaderEnableN
);
    import sera_pkg::*;

    initial begin
        if (QTR_CYC < 8 || QTR_CYC > 65535) $error("QTR_CYC out of range");
        if (WRITE_WAIT_CYC < 1 || WRITE_WAIT_CYC > 16777215) $error("bad WRITE_WAIT_CYC");
        if (IMG_WORDS > 32 || int'(LOAD_ALL_LAST) >= IMG_WORDS
            || LOAD_ALL_LAST < LAST_G4) $error("image size mismatch");
    end

    // ========================================================
    // pin synchronisers
    logic sdaMeta_r, sdaSync_r, enMeta_r, enSync_r;
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            sdaMeta_r <= 1'b1;
            sdaSync_r <= 1'b1;
            enMeta_r  <= 1'b1;
            enSync_r  <= 1'b1;
        end else begin
            sdaMeta_r <= romSerialDataIoIn;
            sdaSync_r <= sdaMeta_r;
            enMeta_r  <= romLoaderEnableN;
            enSync_r  <= enMeta_r;
        end
    end

    // ========================================================
    // state
    sera_main_e      mainSt_r;
    sera_eng_e       engSt_r;
    sera_item_s      item_r;
    sera_item_s      curItem;
    logic [1:0]      phase_r;
    logic [3:0]      slot_r;
    logic [15:0]     qCnt_r;
    logic [2:0]      step_r;
    logic            xWrite_r, xAuto_r, xErr_r;
    logic [6:0]      xAddr_r;
    logic [7:0]      rxByte_r, rxLo_r;
    logic [1:0]      bootCnt_r;
    logic [23:0]     wrCnt_r;
    logic [15:0]     data_r, bridge_r, wrData_r;
    logic [6:0]      ctrlAddr_r, lastWord_r;
    logic            ctrlWrite_r, protect_r, sigOk_r, busy_r;
    logic [IRQ_W-1:0] mask_r, irqStat_r;
    logic [15:0]     image_r [IMG_WORDS];

    // ========================================================
    // decode
    logic loaderOn, abort, qTick, slotEnd, itemEnd, sampleNow, itemGo, xDone;
    logic [2:0] bitIdx;
    logic [15:0] wordIn;
    logic [7:0] byteAddr;
    logic [3:0] regionIn;
    logic [6:0] extentIn, effLast;
    logic sigBad, autoEnd, swStart, wrDone, imgWe;
    logic wrCtrl, wrData, wrMask, wrBridge, rdStat, isImg;
    logic [IRQ_W-1:0] events, irqStatNxt, maskNxt;
    logic [15:0] bridgeNxt;
    logic [31:0] rdMux;
    logic sdaLvl, sclLvl;

    // R04 gate on enable
    assign loaderOn  = !enSync_r;
    assign abort     = !loaderOn && mainSt_r == MS_XFER;
    assign qTick     = engSt_r != ENG_IDLE && qCnt_r == 16'(QTR_CYC - 1);
    assign slotEnd   = qTick && phase_r == 2'd3;
    assign sampleNow = qTick && phase_r == 2'd2;
    assign itemEnd   = slotEnd && (engSt_r == ENG_START || engSt_r == ENG_STOP
                                   || slot_r == 4'd8);
    assign itemGo    = mainSt_r == MS_XFER && engSt_r == ENG_IDLE && loaderOn;
    assign xDone     = itemEnd && item_r.last;
    // R11 address bytes msb first, data bytes lsb first
    assign bitIdx    = item_r.lsbFirst ? slot_r[2:0] : ~slot_r[2:0];
    // R02 little-endian word, byte address is twice the word
    assign wordIn    = {rxByte_r, rxLo_r};
    assign byteAddr  = {xAddr_r, 1'b0};
    // R12 region code picks extent
    assign regionIn  = wordIn[REGION_LSB +: 4];
    assign extentIn  = regionIn == REGION_G2 ? LAST_G2 :
                       regionIn == REGION_G3 ? LAST_G3 :
                       regionIn == REGION_G4 ? LAST_G4 :
                       regionIn == REGION_G5 ? LAST_ALL() : LAST_G1;
    assign effLast   = xAddr_r == REGION_WORD ? extentIn : lastWord_r;
    // R08 exact signature match
    assign sigBad    = xAddr_r == SIG_WORD && wordIn != SIGNATURE;
    assign autoEnd   = xDone && xAuto_r && (xErr_r || sigBad || xAddr_r >= effLast);
    assign wrDone    = mainSt_r == MS_WAITWR && wrCnt_r == 24'(WRITE_WAIT_CYC - 1);
    assign imgWe     = xDone && xAuto_r && !xErr_r && !sigBad;

    function automatic logic [6:0] LAST_ALL();
        return LOAD_ALL_LAST;
    endfunction : LAST_ALL

    // R19 item sequence of one word transfer
    // R05 select byte carries device address zero
    always_comb begin
        curItem = '{kind: ENG_STOP, data: 8'h00, lsbFirst: 1'b0, ackLow: 1'b0, last: 1'b1};
        case (step_r)
            3'd0: curItem = '{ENG_START, 8'h00, 1'b0, 1'b0, 1'b0};
            3'd1: curItem = '{ENG_TX, {ROM_SEL_TYPE, ROM_DEV_ADDR, 1'b0}, 1'b0, 1'b0, 1'b0};
            3'd2: curItem = '{ENG_TX, byteAddr, 1'b0, 1'b0, 1'b0};
            3'd3: curItem = xWrite_r ? '{ENG_TX, wrData_r[7:0], 1'b1, 1'b0, 1'b0}
                                     : '{ENG_START, 8'h00, 1'b0, 1'b0, 1'b0};
            3'd4: curItem = xWrite_r ? '{ENG_TX, wrData_r[15:8], 1'b1, 1'b0, 1'b0}
                                     : '{ENG_TX, {ROM_SEL_TYPE, ROM_DEV_ADDR, 1'b1},
                                         1'b0, 1'b0, 1'b0};
            3'd5: if (!xWrite_r) curItem = '{ENG_RX, 8'h00, 1'b1, 1'b1, 1'b0};
            3'd6: if (!xWrite_r) curItem = '{ENG_RX, 8'h00, 1'b1, 1'b0, 1'b0};
            default: curItem = '{ENG_STOP, 8'h00, 1'b0, 1'b0, 1'b1};
        endcase
    end

    // R03 line levels per quarter; the data line is only ever pulled low
    always_comb begin
        sdaLvl = 1'b1;
        sclLvl = phase_r == 2'd1 || phase_r == 2'd2;
        case (engSt_r)
            ENG_START: sdaLvl = phase_r < 2'd2;
            ENG_STOP: begin
                sdaLvl = phase_r >= 2'd2;
                sclLvl = phase_r != 2'd0;
            end
            ENG_TX:    sdaLvl = slot_r == 4'd8 ? 1'b1 : item_r.data[bitIdx];
            ENG_RX:    sdaLvl = slot_r == 4'd8 ? !item_r.ackLow : 1'b1;
            // clock held low between items so no false start or stop
            default:   sclLvl = mainSt_r != MS_XFER;
        endcase
    end

    // ========================================================
    // bit engine
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            engSt_r <= ENG_IDLE;
            item_r  <= '{ENG_IDLE, 8'h00, 1'b0, 1'b0, 1'b0};
            phase_r <= 2'd0;
            slot_r  <= 4'd0;
            qCnt_r  <= 16'h0000;
        end else if (abort) begin
            engSt_r <= ENG_IDLE;
        end else if (itemGo) begin
            engSt_r <= curItem.kind;
            item_r  <= curItem;
            phase_r <= 2'd0;
            slot_r  <= 4'd0;
            qCnt_r  <= 16'h0000;
        end else if (engSt_r != ENG_IDLE) begin
            qCnt_r  <= qTick ? 16'h0000 : qCnt_r + 16'h0001;
            phase_r <= qTick ? phase_r + 2'd1 : phase_r;
            slot_r  <= slotEnd ? slot_r + 4'd1 : slot_r;
            engSt_r <= itemEnd ? ENG_IDLE : engSt_r;
        end
    end

    // R03 sample at end of the second high quarter; R19 missing ack flags the transfer
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            rxByte_r <= 8'h00;
            rxLo_r   <= 8'h00;
            xErr_r   <= 1'b0;
        end else begin
            if (sampleNow && engSt_r == ENG_RX && slot_r < 4'd8)
                rxByte_r[bitIdx] <= sdaSync_r;
            if (itemEnd && engSt_r == ENG_RX && item_r.ackLow)
                rxLo_r <= rxByte_r;
            if (mainSt_r != MS_XFER || (xDone && !autoEnd))
                xErr_r <= 1'b0;
            else if (sampleNow && engSt_r == ENG_TX && slot_r == 4'd8 && sdaSync_r)
                xErr_r <= 1'b1;
        end
    end

    // ========================================================
    // sequencer
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            mainSt_r   <= MS_BOOT;
            bootCnt_r  <= 2'd0;
            step_r     <= 3'd0;
            xWrite_r   <= 1'b0;
            xAuto_r    <= 1'b0;
            xAddr_r    <= SIG_WORD;
            wrCnt_r    <= 24'h00_0000;
            busy_r     <= 1'b1;
            sigOk_r    <= 1'b0;
            protect_r  <= 1'b0;
            lastWord_r <= LAST_G1;
        end else begin
            case (mainSt_r)
                MS_BOOT: begin
                    bootCnt_r <= bootCnt_r + 2'd1;
                    // R01 self-started load once enable is synchronised
                    if (bootCnt_r == BOOT_WAIT) begin
                        mainSt_r <= loaderOn ? MS_XFER : MS_IDLE;
                        xAuto_r  <= loaderOn;
                        busy_r   <= loaderOn;
                    end
                end
                MS_XFER: begin
                    if (abort) begin
                        mainSt_r <= MS_IDLE;
                        busy_r   <= 1'b0;
                    end else if (xDone) begin
                        step_r <= 3'd0;
                        if (xAuto_r) begin
                            // R18 skipped load or bad signature leaves reset values
                            // R10 busy drops on completion
                            if (autoEnd) begin
                                mainSt_r <= MS_IDLE;
                                busy_r   <= 1'b0;
                            end
                            // R09 next sequential word
                            xAddr_r <= xAddr_r + 7'd1;
                            if (xAddr_r == SIG_WORD && !sigBad && !xErr_r)
                                sigOk_r <= 1'b1;
                            // R13 protect bit and R12 extent latched
                            if (xAddr_r == REGION_WORD && !xErr_r) begin
                                protect_r  <= wordIn[PROTECT_BIT];
                                lastWord_r <= extentIn;
                            end
                        end else begin
                            mainSt_r <= xWrite_r ? MS_WAITWR : MS_IDLE;
                            wrCnt_r  <= 24'h00_0000;
                        end
                    end else if (itemEnd) begin
                        step_r <= step_r + 3'd1;
                    end
                end
                MS_WAITWR: begin
                    wrCnt_r  <= wrCnt_r + 24'h00_0001;
                    mainSt_r <= wrDone ? MS_IDLE : MS_WAITWR;
                end
                default: begin
                    // R06 one word access per start
                    if (swStart) begin
                        mainSt_r <= MS_XFER;
                        xAuto_r  <= 1'b0;
                        xWrite_r <= regBus.wdata[CTRL_WRITE_BIT];
                        xAddr_r  <= regBus.wdata[CTRL_ADDR_LSB +: 7];
                        step_r   <= 3'd0;
                    end
                end
            endcase
        end
    end

    // R14 R15 R16 image words hold identity, prefetch and power fields
    for (genvar i = 0; i < IMG_WORDS; i++) begin : gImg
        always_ff @(posedge clk) begin
            if (!rst_b)
                image_r[i] <= IMG_RST;
            else if (imgWe && xAddr_r == 7'(i))
                image_r[i] <= wordIn;
        end
    end

    // ========================================================
    // register port
    assign wrCtrl   = regBus.wr && regBus.addr == REG_CTRL;
    assign wrData   = regBus.wr && regBus.addr == REG_DATA;
    assign wrMask   = regBus.wr && regBus.addr == REG_IRQ_MASK;
    assign wrBridge = regBus.wr && regBus.addr == REG_BRIDGE;
    assign rdStat   = regBus.rd && regBus.addr == REG_IRQ_STAT;
    assign isImg    = regBus.addr[IMG_SEL_BIT];
    // R07 start ignored while a cycle or the load runs
    assign swStart  = wrCtrl && regBus.wdata[CTRL_START_BIT] && mainSt_r == MS_IDLE
                      && loaderOn;
    // R13 protected bit keeps its value
    assign bridgeNxt = protect_r
        ? {regBus.wdata[15:BRIDGE_WP_BIT+1], bridge_r[BRIDGE_WP_BIT],
           regBus.wdata[BRIDGE_WP_BIT-1:0]}
        : regBus.wdata[15:0];
    assign events[IRQ_LOAD_DONE] = autoEnd || (mainSt_r == MS_BOOT && bootCnt_r == BOOT_WAIT);
    assign events[IRQ_SW_DONE]   = (xDone && !xAuto_r && !xWrite_r) || wrDone;
    assign events[IRQ_ACK_ERR]   = (xDone && xErr_r) || abort;
    // set wins over the read clear
    assign irqStatNxt = (rdStat ? '0 : irqStat_r) | events;
    assign maskNxt    = wrMask ? regBus.wdata[IRQ_W-1:0] : mask_r;

    always_comb begin
        rdMux = 32'h0000_0000;
        if (isImg && int'(regBus.addr[6:2]) < IMG_WORDS)
            rdMux = {16'h0000, image_r[regBus.addr[6:2]]};
        else if (regBus.addr == REG_CTRL)
            rdMux = {16'h0000, 1'b0, ctrlAddr_r, 6'h00, ctrlWrite_r, 1'b0};
        else if (regBus.addr == REG_DATA)
            rdMux = {16'h0000, data_r};
        else if (regBus.addr == REG_STATUS)
            rdMux = {27'h000_0000, protect_r, loaderOn, sigOk_r,
                     mainSt_r != MS_IDLE, busy_r};
        else if (regBus.addr == REG_IRQ_STAT)
            rdMux = {29'h0000_0000, irqStat_r};
        else if (regBus.addr == REG_IRQ_MASK)
            rdMux = {29'h0000_0000, mask_r};
        else if (regBus.addr == REG_BRIDGE)
            rdMux = {16'h0000, bridge_r};
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            ctrlWrite_r <= 1'b0;
            ctrlAddr_r  <= 7'h00;
            data_r      <= 16'h0000;
            wrData_r    <= 16'h0000;
            bridge_r    <= BRIDGE_RST;
            mask_r      <= '0;
            irqStat_r   <= '0;
            rdData      <= 32'h0000_0000;
            irq         <= 1'b0;
        end else begin
            if (wrCtrl) begin
                ctrlWrite_r <= regBus.wdata[CTRL_WRITE_BIT];
                ctrlAddr_r  <= regBus.wdata[CTRL_ADDR_LSB +: 7];
            end
            if (xDone && !xAuto_r && !xWrite_r)
                data_r <= wordIn;
            else if (wrData)
                data_r <= regBus.wdata[15:0];
            if (swStart)
                wrData_r <= data_r;
            if (wrBridge)
                bridge_r <= bridgeNxt;
            mask_r    <= maskNxt;
            irqStat_r <= irqStatNxt;
            rdData    <= regBus.rd ? rdMux : 32'h0000_0000;
            irq       <= |(irqStatNxt & maskNxt);
        end
    end

    // ========================================================
    // pin outputs
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            romSerialClockOut  <= 1'b1;
            romSerialDataIoOut <= 1'b1;
            romSerialDataIoOe  <= 1'b0;
            autoloadBusyStatus <= 1'b1;
        end else begin
            romSerialClockOut  <= sclLvl;
            romSerialDataIoOut <= sdaLvl;
            romSerialDataIoOe  <= !sdaLvl;
            autoloadBusyStatus <= busy_r;
        end
    end

    // ========================================================
    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    chk_boot_start: assert property ( // R01
        mainSt_r == MS_BOOT && bootCnt_r == BOOT_WAIT && loaderOn
        |=> mainSt_r == MS_XFER && xAuto_r && busy_r ##1 engSt_r == ENG_START)
        else $error("load did not start after reset");
    chk_disabled_quiet: assert property ( // R04
        !loaderOn && mainSt_r != MS_BOOT |=> engSt_r == ENG_IDLE)
        else $error("rom activity while disabled");
    chk_select_zero: assert property ( // R05
        itemGo && curItem.kind == ENG_TX && (step_r == 3'd1 || (step_r == 3'd4 && !xWrite_r))
        |-> curItem.data[3:1] == ROM_DEV_ADDR && curItem.data[7:4] == ROM_SEL_TYPE)
        else $error("select byte not device zero");
    chk_sw_one_word: assert property ( // R06
        swStart |=> mainSt_r == MS_XFER && !xAuto_r && step_r == 3'd0
        && xAddr_r == $past(regBus.wdata[CTRL_ADDR_LSB +: 7]))
        else $error("software start not taken");
    chk_sig_gate: assert property ( // R08
        xDone && xAuto_r && sigBad |=> mainSt_r == MS_IDLE && !busy_r && !sigOk_r)
        else $error("load continued after bad signature");
    chk_seq_addr: assert property ( // R09
        xDone && xAuto_r && !autoEnd |=> xAddr_r == $past(xAddr_r) + 7'd1
        && mainSt_r == MS_XFER)
        else $error("load address not sequential");
    chk_busy_fall: assert property ( // R10
        $fell(autoloadBusyStatus) |-> mainSt_r == MS_IDLE && $past(!busy_r))
        else $error("busy dropped while loading");
    chk_data_order: assert property ( // R11
        engSt_r == ENG_TX && item_r.lsbFirst && slot_r == 4'd0 && phase_r == 2'd1
        |-> sdaLvl == item_r.data[0])
        else $error("data byte not lsb first");
    chk_wp_hold: assert property ( // R13
        wrBridge && protect_r |=> bridge_r[BRIDGE_WP_BIT] == $past(bridge_r[BRIDGE_WP_BIT]))
        else $error("protected bridge bit changed");
    chk_scl_quarter: assert property ( // R03
        $changed(sclLvl) && engSt_r != ENG_IDLE && $past(engSt_r) == engSt_r
        |-> $past(qTick))
        else $error("serial clock moved off a quarter");

    cov_load_done: cover property (xDone && xAuto_r && xAddr_r == LAST_G4 && autoEnd);
    cov_sw_write:  cover property (wrDone);
    cov_ack_err:   cover property (xDone && xErr_r);
endmodule : sera_autoloader

//--- tb/sera_rom_model.sv
// two-wire rom model, 256 bytes, address straps at zero
// assumes an open-drain data line with a pull-up in the bench
`timescale 1ns/1ps
module sera_rom_model #(
    parameter logic [15:0] W0 = 16'h0000,
    parameter logic [15:0] W1 = 16'h0000
) (
    input  wire logic scl,
    input  wire logic sda,
    output logic      pullLow
);
    logic [7:0] sh, ptr, mem [256];
    logic       rd = 0;
    // master ack of the last read byte; a nack ends the read
    logic       mAck = 0;
    int         bitN = 0;
    int         byteN = 0;
    initial begin
        for (int i = 0; i < 256; i++) mem[i] = 8'(i * 3);
        {mem[3], mem[2], mem[1], mem[0]} = {W1, W0};
        pullLow = 0;
    end
    always @(negedge sda) if (scl) begin
        {bitN, byteN, rd, pullLow} = '0;
    end
    always @(posedge scl) begin
        if (bitN < 8) sh = {sh[6:0], sda};
        else if (bitN == 8) mAck = !sda;
        bitN++;
    end
    // ack only select zero, address msb first, data lsb first
    always @(negedge scl) if (bitN == 8) begin
        pullLow = !(rd && byteN > 0) && !(byteN == 0 && sh[7:1] !== 7'h50);
        if (byteN == 0) rd = sh[0];
        else if (!rd && byteN == 1) ptr = sh;
        else if (!rd) begin
            mem[ptr] = {<<{sh}};
            ptr++;
        end
    end else begin
        if (bitN == 9) begin
            // release the line after a nack so stop and restart are seen
            if (rd && byteN > 0) begin
                ptr++;
                rd = mAck;
            end
            bitN = 0;
            byteN++;
        end
        pullLow = rd && byteN > 0 && !mem[ptr][bitN];
    end
endmodule : sera_rom_model

//--- tb/sera_autoloader_tb_top.sv
// self-checking bench of the serial rom autoloader
// assumes sera_rom_model on the link and a pull-up on the data line
`timescale 1ns/1ps
module sera_autoloader_tb_top;
    import sera_pkg::*;
    // arbitrary signature; region code 0001 with protect set
    localparam logic [15:0] SIG = 16'hC35A, W1 = 16'h0102;
    logic        clk = 0, rstB = 0, enN = 0, irq, busy, scl, sdaO, sdaOe, pullLow;
    logic [31:0] rdData, rv;
    sera_bus_s   bus = '0;
    wire         sda = !(sdaOe || pullLow);
    int          errorCnt = 0, samplesChecked = 0;
    sera_autoloader #(.QTR_CYC(8), .WRITE_WAIT_CYC(10), .SIGNATURE(SIG)) sera_autoloader_inst (
        .clk(clk), .rst_b(rstB), .regBus(bus), .rdData(rdData), .irq(irq),
        .autoloadBusyStatus(busy), .romSerialClockOut(scl), .romSerialDataIoIn(sda),
        .romSerialDataIoOut(sdaO), .romSerialDataIoOe(sdaOe), .romLoaderEnableN(enN));
    sera_rom_model #(.W0(SIG), .W1(W1)) sera_rom_model_inst (
        .scl(scl), .sda(sda), .pullLow(pullLow));
    initial forever #12.5 clk = ~clk;
    initial begin
        repeat (60000) @(posedge clk);
        errorCnt++;
        test_done();
    end
    task automatic test_done();
        if (errorCnt == 0 && samplesChecked > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : test_done
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        samplesChecked++;
        if (s !== e) begin
            errorCnt++;
            $display("FAIL t=%0t got %h exp %h", $time, s, e);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk) bus <= '{a, d, 1'b1, 1'b0};
        @(posedge clk) bus.wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a);
        @(posedge clk) bus <= '{a, 32'h0, 1'b0, 1'b1};
        @(posedge clk) bus.rd <= 1'b0;
        #1 rv = rdData;
    endtask : rd
    // polls the cycle bit; a run-out counts as a mismatch
    task automatic idle_wait();
        repeat (4) @(posedge clk);
        for (int i = 0; i < 15000; i++) begin
            rd(REG_STATUS);
            if (rv[ST_CYCLE] === 1'b0) break;
        end
        chk(rv[ST_CYCLE], 0);
    endtask : idle_wait
    initial begin
        repeat (10) @(posedge clk);
        chk(busy, 1);
        rstB <= 1'b1;
        idle_wait();
        chk(busy, 0);
        for (int n = 0; n < 11; n++) begin
            rd(8'h80 + 8'(4 * n));
            chk(rv, n == 0 ? 32'(SIG) : n == 1 ? 32'(W1) : n > 9 ? 32'h0 : {16'h0, 8'(6*n+3), 8'(6*n)});
        end
        rd(REG_STATUS);
        chk(rv, 32'h0000_001C);
        wr(REG_IRQ_MASK, 32'h0000_0001);
        repeat (2) @(posedge clk);
        #1 chk(irq, 1);
        rd(REG_IRQ_STAT);
        chk(rv, 32'h0000_0001);
        repeat (2) @(posedge clk);
        #1 chk(irq, 0);
        wr(REG_BRIDGE, 32'h0000_FFFF);
        rd(REG_BRIDGE);
        chk(rv, 32'h0000_FFFB);
        wr(REG_DATA, 32'h0000_1234);
        wr(REG_CTRL, 32'h0000_0503);
        idle_wait();
        chk({sera_rom_model_inst.mem[11], sera_rom_model_inst.mem[10]}, 32'h0000_1234);
        wr(REG_DATA, 32'h0);
        wr(REG_CTRL, 32'h0000_0501);
        idle_wait();
        rd(REG_DATA);
        chk(rv, 32'h0000_1234);
        @(posedge clk);
        enN <= 1'b1;
        rstB <= 1'b0;
        repeat (10) @(posedge clk);
        rstB <= 1'b1;
        repeat (12) @(posedge clk);
        #1 chk(busy, 0);
        rd(8'h80);
        chk(rv, 32'h0);
        wr(REG_CTRL, 32'h0000_0501);
        repeat (40) @(posedge clk);
        #1 chk({scl, sdaO, sdaOe}, 3'b110);
        test_done();
    end
endmodule : sera_autoloader_tb_top
